// ===== pkg/cmbi_pkg.sv
// Constants, request and answer carriers and sequencer states for the
// connection memory block fill logic.
// Assumes one 25 MHz clock shared with the host control port.
package cmbi_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int FILL_TIME_US  = 120;
  localparam int FILL_CYCLES   = (FILL_TIME_US * 1000) / CLK_PERIOD_NS;

  localparam int ADDR_W   = 19;
  localparam int DATA_W   = 32;
  localparam int TDM_N    = 64;
  localparam int WORD_LSB = 2;

  localparam logic [ADDR_W-1:0] ADDR_FILL_VALUE = 19'h40288;
  localparam logic [ADDR_W-1:0] ADDR_TRIGGER    = 19'h4028C;
  localparam logic [ADDR_W-1:0] ADDR_REG_BASE   = 19'h40000;

  localparam logic [DATA_W-1:0] FILL_KEY       = 32'h31415926;
  localparam logic [DATA_W-1:0] FILL_VALUE_RST = 32'h00000000;

  localparam int STAT_BLOCK_BIT = 0;
  localparam int STAT_RESET_BIT = 1;

  typedef struct packed {
    logic              valid;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cmbi_req_s;

  typedef struct packed {
    logic              ack;
    logic              bus_error_response;
    logic [DATA_W-1:0] rdata;
  } cmbi_rsp_s;

  typedef enum logic [2:0] {
    SEQ_BOOT = 3'b001,
    SEQ_IDLE = 3'b010,
    SEQ_FILL = 3'b100
  } cmbi_seq_e;
endpackage

// ===== verilog/cmbi_mem.sv
// Single-port connection memory with registered read data.
// Assumes one access per clock; the caller muxes fill and host traffic.
`timescale 1ns/1ns
module cmbi_mem #(
  parameter int DEPTH = 3000,
  parameter int W     = 32,
  parameter int AW    = 12
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [W-1:0]  i_wdata,
  output logic      [W-1:0]  o_rdata
);
  logic [W-1:0] mem_r [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_addr] <= i_wdata;
    end
    o_rdata <= mem_r[i_addr];
  end
endmodule

// ===== verilog/cmbi_seq.sv
// Fill sequencer: walks every connection memory word with a latched value.
// Assumes the caller only raises i_start while o_busy is low.
`timescale 1ns/1ns
module cmbi_seq
  import cmbi_pkg::*;
#(
  parameter int DEPTH = 3000,
  parameter int AW    = 12
) (
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_start,
  input  wire logic [DATA_W-1:0] i_fill_value,
  output logic                   o_busy,
  output logic                   o_rst_init,
  output logic                   o_we,
  output logic      [AW-1:0]     o_addr,
  output logic      [DATA_W-1:0] o_wdata
);
  import cmbi_pkg::*;

  cmbi_seq_e         state_r;
  cmbi_seq_e         state_nxt;
  logic [AW-1:0]     cnt_r;
  logic [AW-1:0]     cnt_nxt;
  logic [DATA_W-1:0] val_r;
  logic [DATA_W-1:0] val_nxt;
  logic              rst_init_r;
  logic              rst_init_nxt;

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    val_nxt      = val_r;
    rst_init_nxt = rst_init_r;
    unique case (state_r)
      SEQ_BOOT: begin
        state_nxt = SEQ_FILL;
        cnt_nxt   = '0;
        val_nxt   = FILL_VALUE_RST;
      end
      SEQ_IDLE: begin
        if (i_start) begin
          state_nxt = SEQ_FILL;
          cnt_nxt   = '0;
          val_nxt   = i_fill_value;
        end
      end
      SEQ_FILL: begin
        if (cnt_r == AW'(DEPTH - 1)) begin
          state_nxt    = SEQ_IDLE;
          rst_init_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r    <= SEQ_BOOT;
      cnt_r      <= '0;
      val_r      <= FILL_VALUE_RST;
      rst_init_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      val_r      <= val_nxt;
      rst_init_r <= rst_init_nxt;
    end
  end

  assign o_busy     = (state_r != SEQ_IDLE);
  assign o_rst_init = rst_init_r;
  assign o_we       = (state_r == SEQ_FILL);
  assign o_addr     = cnt_r;
  assign o_wdata    = val_r;
endmodule

// ===== verilog/cmbi_top.sv
// Connection memory block fill: fill value and trigger registers, the
// connection memory itself, access blocking and TDM output disable.
// Assumes the host control port runs on i_clk and keeps one request a cycle.
//
// How it works
// - A 32-bit read/write fill value register sits at 040288.
// - A fill copies the fill value into every connection memory word.
// - A whole fill takes about 120 us, one word per clock.
// - The value used by a fill is latched at its start; later writes apply to the next fill.
// - Reset clears the fill value and runs a zero fill automatically.
// - A 32-bit trigger register at 04028C starts a fill while no fill is running.
// - Only a write of 31415926 to the trigger starts a fill.
// - A start request during a running fill is ignored.
// - Trigger read bit 0 shows a fill in progress.
// - Trigger read bit 1 shows the power-up fill in progress.
// - Trigger read bits 31 to 2 are zero.
// - Memory accesses during any fill end with a bus error.
// - All TDM outputs stay in high impedance while a fill runs.
`timescale 1ns/1ns
module cmbi_top
  import cmbi_pkg::*;
#(
  parameter int CM_DEPTH = FILL_CYCLES,
  parameter int N_TDM    = TDM_N
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rstn,
  input  wire cmbi_pkg::cmbi_req_s   i_req,
  output cmbi_pkg::cmbi_rsp_s        o_rsp,
  input  wire logic [N_TDM-1:0]      i_tdm_oe,
  output logic      [N_TDM-1:0]      o_tdm_oe,
  output logic                       o_dm_grant
);
  import cmbi_pkg::*;

  localparam int CM_AW  = $clog2(CM_DEPTH);
  localparam int WORD_W = ADDR_W - WORD_LSB;

  function automatic logic in_mem(input logic [ADDR_W-1:0] a);
    return (a < ADDR_REG_BASE);
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    return (a == r);
  endfunction

  logic              seq_busy;
  logic              seq_rst_init;
  logic              seq_we;
  logic [CM_AW-1:0]  seq_addr;
  logic [DATA_W-1:0] seq_wdata;

  logic              mem_we;
  logic [CM_AW-1:0]  mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;

  logic              fill_wr;
  logic              trig_wr;
  logic              key_wr;
  logic              start;
  logic              mem_hit;
  logic              blocked;
  logic [WORD_W-1:0] word_idx;
  logic              cm_ok;
  logic              dm_ok;
  logic [DATA_W-1:0] status;

  logic [DATA_W-1:0] fill_value_r;
  logic [DATA_W-1:0] fill_value_nxt;
  logic [N_TDM-1:0]  tdm_oe_r;
  logic [N_TDM-1:0]  tdm_oe_nxt;
  logic              p1_valid_r;
  logic              p1_valid_nxt;
  logic              p1_err_r;
  logic              p1_err_nxt;
  logic              p1_rd_cm_r;
  logic              p1_rd_cm_nxt;
  logic              p1_rd_fill_r;
  logic              p1_rd_fill_nxt;
  logic              p1_rd_trig_r;
  logic              p1_rd_trig_nxt;
  logic              dm_grant_r;
  logic              dm_grant_nxt;
  cmbi_rsp_s         rsp_r;
  cmbi_rsp_s         rsp_nxt;

  cmbi_seq #(
    .DEPTH (CM_DEPTH),
    .AW    (CM_AW)
  ) u_seq (
    .i_clk        (i_clk),
    .i_rstn       (i_rstn),
    .i_start      (start),
    .i_fill_value (fill_value_r),
    .o_busy       (seq_busy),
    .o_rst_init   (seq_rst_init),
    .o_we         (seq_we),
    .o_addr       (seq_addr),
    .o_wdata      (seq_wdata)
  );

  cmbi_mem #(
    .DEPTH (CM_DEPTH),
    .W     (DATA_W),
    .AW    (CM_AW)
  ) u_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  always_comb begin
    fill_wr  = i_req.valid && i_req.wr && reg_hit(i_req.addr, ADDR_FILL_VALUE);
    trig_wr  = i_req.valid && i_req.wr && reg_hit(i_req.addr, ADDR_TRIGGER);
    key_wr   = trig_wr && (i_req.wdata == FILL_KEY);
    start    = key_wr && !seq_busy;
    mem_hit  = i_req.valid && in_mem(i_req.addr);
    blocked  = mem_hit && seq_busy;
    word_idx = i_req.addr[ADDR_W-1:WORD_LSB];
    cm_ok    = i_req.valid && !seq_busy && (word_idx < WORD_W'(CM_DEPTH));
    dm_ok    = mem_hit && !seq_busy && !cm_ok;
    status   = '0;
    status[STAT_BLOCK_BIT] = seq_busy;
    status[STAT_RESET_BIT] = seq_rst_init;
  end

  always_comb begin
    if (seq_busy) begin
      mem_we    = seq_we;
      mem_addr  = seq_addr;
      mem_wdata = seq_wdata;
    end else begin
      mem_we    = cm_ok && i_req.wr;
      mem_addr  = word_idx[CM_AW-1:0];
      mem_wdata = i_req.wdata;
    end
  end

  always_comb begin
    fill_value_nxt = fill_value_r;
    if (fill_wr) begin
      fill_value_nxt = i_req.wdata;
    end
    if (seq_busy || start) begin
      tdm_oe_nxt = '0;
    end else begin
      tdm_oe_nxt = i_tdm_oe;
    end
    p1_valid_nxt   = i_req.valid;
    p1_err_nxt     = blocked;
    p1_rd_cm_nxt   = cm_ok && !i_req.wr;
    p1_rd_fill_nxt = i_req.valid && !i_req.wr && reg_hit(i_req.addr, ADDR_FILL_VALUE);
    p1_rd_trig_nxt = i_req.valid && !i_req.wr && reg_hit(i_req.addr, ADDR_TRIGGER);
    dm_grant_nxt   = dm_ok;
    rsp_nxt.ack                = p1_valid_r;
    rsp_nxt.bus_error_response = p1_err_r;
    if (p1_rd_cm_r) begin
      rsp_nxt.rdata = mem_rdata;
    end else if (p1_rd_fill_r) begin
      rsp_nxt.rdata = fill_value_r;
    end else if (p1_rd_trig_r) begin
      rsp_nxt.rdata = status;
    end else begin
      rsp_nxt.rdata = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fill_value_r <= FILL_VALUE_RST;
      tdm_oe_r     <= '0;
      p1_valid_r   <= 1'b0;
      p1_err_r     <= 1'b0;
      p1_rd_cm_r   <= 1'b0;
      p1_rd_fill_r <= 1'b0;
      p1_rd_trig_r <= 1'b0;
      dm_grant_r   <= 1'b0;
      rsp_r        <= '0;
    end else begin
      fill_value_r <= fill_value_nxt;
      tdm_oe_r     <= tdm_oe_nxt;
      p1_valid_r   <= p1_valid_nxt;
      p1_err_r     <= p1_err_nxt;
      p1_rd_cm_r   <= p1_rd_cm_nxt;
      p1_rd_fill_r <= p1_rd_fill_nxt;
      p1_rd_trig_r <= p1_rd_trig_nxt;
      dm_grant_r   <= dm_grant_nxt;
      rsp_r        <= rsp_nxt;
    end
  end

  assign o_rsp      = rsp_r;
  assign o_tdm_oe   = tdm_oe_r;
  assign o_dm_grant = dm_grant_r;

  // Helper counter of consecutive fill write cycles, read only by checks.
  int fill_len_r;
  int fill_len_nxt;

  always_comb begin
    fill_len_nxt = seq_we ? fill_len_r + 1 : 0;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fill_len_r <= 0;
    end else begin
      fill_len_r <= fill_len_nxt;
    end
  end

  chk_fill_reg_write: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    fill_wr |=> (fill_value_r == $past(i_req.wdata)))
    else $error("Fill value register did not take the written word.");

  chk_fill_copies_value: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    start |-> ##1 (mem_we && mem_addr == '0 && mem_wdata == $past(fill_value_r)))
    else $error("Fill did not begin writing the latched value at word zero.");

  chk_fill_length: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    $fell(seq_we) |-> (fill_len_r == CM_DEPTH))
    else $error("Fill did not last one cycle per memory word.");

  chk_fill_value_held: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (seq_we && $past(seq_we)) |-> $stable(mem_wdata))
    else $error("Fill data changed in the middle of a fill.");

  chk_powerup_zero: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (seq_rst_init && seq_we) |-> (mem_wdata == FILL_VALUE_RST))
    else $error("Power-up fill wrote a non-zero word.");

  chk_key_starts: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (key_wr && !seq_busy) |=> (seq_busy && status[STAT_BLOCK_BIT]))
    else $error("Key write while idle did not start a fill.");

  chk_bad_key_ignored: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (trig_wr && !key_wr && !seq_busy) |=> !seq_busy)
    else $error("A non-key trigger write started a fill.");

  chk_restart_ignored: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (key_wr && seq_we && seq_addr != CM_AW'(CM_DEPTH - 1)) |=>
      (seq_we && seq_addr == $past(seq_addr) + 1'b1))
    else $error("Key write during a fill disturbed the running fill.");

  chk_status_read: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (i_req.valid && !i_req.wr && i_req.addr == ADDR_TRIGGER) |-> ##2
      (o_rsp.ack && o_rsp.rdata == {30'h0, $past(seq_rst_init), $past(seq_busy)}))
    else $error("Trigger read-back did not show the fill status.");

  chk_bus_error: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (mem_hit && seq_busy) |-> ##2 (o_rsp.ack && o_rsp.bus_error_response))
    else $error("Memory access during a fill was not refused.");

  chk_tdm_hiz: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    seq_busy |-> (o_tdm_oe == '0))
    else $error("A TDM output was enabled during a fill.");

  chk_busy_falls: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    $fell(seq_busy) |-> $past(seq_we && seq_addr == CM_AW'(CM_DEPTH - 1)))
    else $error("Busy fell other than right after the last word.");

  chk_dm_grant_idle: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    dm_ok |=> o_dm_grant)
    else $error("Accepted data memory access raised no grant.");

  chk_dm_refused: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (mem_hit && seq_busy) |=> !o_dm_grant)
    else $error("Data memory was granted during a fill.");

  chk_mem_served: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (mem_hit && !seq_busy) |-> ##2 (o_rsp.ack && !o_rsp.bus_error_response))
    else $error("Memory access while idle was refused.");

  chk_tdm_follows: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (!seq_busy && !start) |=> (o_tdm_oe == $past(i_tdm_oe)))
    else $error("TDM enables did not follow the request while idle.");

  chk_reset_bit_busy: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    seq_rst_init |-> seq_busy)
    else $error("Reset fill status shown without a running fill.");

  chk_fill_ends_idle: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (seq_we && seq_addr == CM_AW'(CM_DEPTH - 1)) |=> !seq_busy)
    else $error("Busy stayed high after the last word.");
endmodule

// ===== bench/cmbi_host.sv
// Host model for the fill block control port: one access per call.
// Assumes requests launch at falling edges and answers follow within a few edges.
`timescale 1ns/1ns
module cmbi_host
  import cmbi_pkg::*;
(
  input  wire cmbi_pkg::cmbi_rsp_s i_rsp,
  input  wire logic                i_clk,
  output cmbi_pkg::cmbi_req_s      o_req
);
  import cmbi_pkg::*;

  initial begin
    o_req = '0;
  end

  // Issues one access and waits a bounded time for its answer.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] rd, output logic er, output logic ok);
    ok = 1'b0;
    rd = '0;
    er = 1'b0;
    @(negedge i_clk);
    o_req = '{valid: 1'b1, wr: wr, addr: a, wdata: d};
    for (int k = 0; k < 5 && !ok; k++) begin
      @(negedge i_clk);
      o_req.valid = 1'b0;
      o_req.addr  = ~a;
      o_req.wdata = ~d;
      if (i_rsp.ack === 1'b1) begin
        ok = 1'b1;
        rd = i_rsp.rdata;
        er = i_rsp.bus_error_response;
      end
    end
  endtask

  // Writes the start key to the trigger register.
  task automatic start_fill(output logic ok);
    logic [DATA_W-1:0] rd;
    logic              er;
    xfer(1'b1, ADDR_TRIGGER, FILL_KEY, rd, er, ok);
  endtask
endmodule

// ===== bench/tb_cmbi_top.sv
// Self-checking bench for the connection memory block fill.
// Assumes the host model drives the control port; TDM enables come from here.
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_cmbi_top;
  import cmbi_pkg::*;
  localparam int          DEPTH  = 40;
  localparam logic [63:0] OE_PAT = 64'hF0F0_0FF0_A5A5_3C3C;
  localparam logic [31:0] FV1    = 32'hA5A5_5A5A;
  localparam logic [31:0] FV2    = 32'h0F0F_F0F0;

  logic        i_clk = 1'b0;
  logic        i_rstn;
  cmbi_req_s   req;
  cmbi_rsp_s   rsp;
  logic [63:0] tdm_in;
  logic [63:0] tdm_out;
  logic        dm_grant;
  logic [31:0] rd;
  logic        er;
  logic        ok;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          t0;
  int          dm_pulses = 0;

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;

  // Counts grant pulses while they stand, sampled away from the launching edge.
  always @(negedge i_clk) begin
    if (dm_grant === 1'b1) begin
      dm_pulses <= dm_pulses + 1;
    end
  end

  cmbi_top #(.CM_DEPTH(DEPTH), .N_TDM(64)) cmbi_top_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_req(req), .o_rsp(rsp),
    .i_tdm_oe(tdm_in), .o_tdm_oe(tdm_out), .o_dm_grant(dm_grant));

  cmbi_host cmbi_host_i (.i_rsp(rsp), .i_clk(i_clk), .o_req(req));

  task automatic end_sim();
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Runs one access and compares answer, error flag and read data.
  task automatic acc(input string nm, input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic e_err, input logic [DATA_W-1:0] e_rd);
    cmbi_host_i.xfer(wr, a, d, rd, er, ok);
    `CHK(nm, {1'b1, e_err, e_rd}, {ok, er, rd})
  endtask

  // Polls the status word until the fill bit clears, bounded.
  task automatic wait_idle();
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 80) begin
      cmbi_host_i.xfer(1'b0, ADDR_TRIGGER, '0, rd, er, ok);
      n++;
    end
    `CHK("fill done", 2'b10, {ok, rd[0]})
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    end_sim();
  end

  initial begin
    i_rstn = 1'b0;
    tdm_in = OE_PAT;
    repeat (4) @(negedge i_clk);
    i_rstn = 1'b1;
    `CHK("tdm during boot", 64'h0, tdm_out)
    acc("boot status", 1'b0, ADDR_TRIGGER, '0, 1'b0, 32'h3);
    acc("boot memory", 1'b0, 19'h00004, '0, 1'b1, '0);
    acc("fill value reset", 1'b0, ADDR_FILL_VALUE, '0, 1'b0, FILL_VALUE_RST);
    wait_idle();
    acc("idle status", 1'b0, ADDR_TRIGGER, '0, 1'b0, '0);
    for (int k = 0; k < DEPTH; k++) begin
      acc("boot word", 1'b0, ADDR_W'(4 * k), '0, 1'b0, '0);
    end
    `CHK("tdm idle", OE_PAT, tdm_out)
    acc("fill value write", 1'b1, ADDR_FILL_VALUE, FV1, 1'b0, '0);
    acc("fill value read", 1'b0, ADDR_FILL_VALUE, '0, 1'b0, FV1);
    acc("wrong key", 1'b1, ADDR_TRIGGER, FILL_KEY ^ 32'h1, 1'b0, '0);
    acc("no fill", 1'b0, ADDR_TRIGGER, '0, 1'b0, '0);
    acc("memory write", 1'b1, 19'h0000C, 32'h1234_5678, 1'b0, '0);
    acc("memory read", 1'b0, 19'h0000C, '0, 1'b0, 32'h1234_5678);
    acc("data memory idle", 1'b1, 19'h20000, 32'hFFFF_FFFF, 1'b0, '0);
    `CHK("dm grant idle", 1, dm_pulses)
    t0 = cyc;
    cmbi_host_i.start_fill(ok);
    `CHK("key answer", 1'b1, ok)
    `CHK("tdm during fill", 64'h0, tdm_out)
    acc("fill status", 1'b0, ADDR_TRIGGER, '0, 1'b0, 32'h1);
    acc("fill value busy", 1'b1, ADDR_FILL_VALUE, FV2, 1'b0, '0);
    acc("key while busy", 1'b1, ADDR_TRIGGER, FILL_KEY, 1'b0, '0);
    acc("memory busy", 1'b0, 19'h00008, '0, 1'b1, '0);
    acc("data memory busy", 1'b1, 19'h20000, 32'hFFFF_FFFF, 1'b1, '0);
    `CHK("dm grant busy", 1, dm_pulses)
    wait_idle();
    `CHK("fill span", 1'b1, (cyc - t0 >= DEPTH) && (cyc - t0 <= DEPTH + 9))
    for (int k = 0; k < DEPTH; k++) begin
      acc("filled word", 1'b0, ADDR_W'(4 * k), '0, 1'b0, FV1);
    end
    acc("new fill value", 1'b0, ADDR_FILL_VALUE, '0, 1'b0, FV2);
    `CHK("tdm after fill", OE_PAT, tdm_out)
    tdm_in = ~OE_PAT;
    repeat (2) @(negedge i_clk);
    `CHK("tdm follows", ~OE_PAT, tdm_out)
    i_rstn = 1'b0;
    @(negedge i_clk);
    `CHK("tdm in reset", 64'h0, tdm_out)
    i_rstn = 1'b1;
    acc("reboot status", 1'b0, ADDR_TRIGGER, '0, 1'b0, 32'h3);
    acc("reboot fill value", 1'b0, ADDR_FILL_VALUE, '0, 1'b0, FILL_VALUE_RST);
    wait_idle();
    acc("reboot word", 1'b0, 19'h0000C, '0, 1'b0, '0);
    end_sim();
  end
endmodule
